// ---- common/drv_regs_pkg.sv ----
// package: control/status and fault register layout for the current driver
package drv_regs_pkg;

    // command codes seen on the command port
    typedef enum logic [1:0] {
        CMD_NONE        = 2'b00,
        CMD_READ_CTRL   = 2'b01,
        CMD_WRITE_CTRL  = 2'b10,
        CMD_READ_FAULT  = 2'b11
    } cmd_type;

    // control register bit positions
    localparam int CTL_OUTPUT_ON      = 0;
    localparam int CTL_EXT_SETPOINT   = 1;
    localparam int CTL_ENABLE_STATE   = 2;
    localparam int CTL_NO_FAULT       = 3;
    localparam int CTL_PRESETS_PWRUP  = 4;
    localparam int CTL_ENABLE_SRC_PIN = 6;
    localparam int CTL_SETPOINT_RANGE = 7;

    // fault register bit positions
    localparam int FLT_OVERTEMP_OFF   = 0;
    localparam int FLT_CONFIG_BAD     = 1;
    localparam int FLT_PRESET_BAD     = 2;
    localparam int FLT_IMAGE_BAD      = 3;
    localparam int FLT_CALIB_BAD      = 5;
    localparam int FLT_PRESET_LOAD    = 7;
    localparam int FLT_TEMP_OVER      = 8;
    localparam int FLT_COOLDOWN       = 9;
    localparam int FLT_HEAT_ALERT     = 10;
    localparam int FLT_STORE_BUS      = 11;
    localparam int FLT_PIN_STARTUP    = 12;
    localparam int FLT_PIN_SWITCH     = 13;
    localparam int FLT_REG_SATURATED  = 15;
    localparam int FLT_CUR_WINDOW     = 16;

    // writable control bits and implemented fault bits
    localparam logic [31:0] CTL_WRITE_MASK = 32'h0000_00d7;
    localparam logic [31:0] FLT_IMPL_MASK  = 32'h0001_bfaf;
    // self-test flags: cleared only by power cycle
    localparam logic [31:0] FLT_STICKY_MASK = 32'h0000_002e;
    // control reset: output on, everything else off
    localparam logic [31:0] CTL_RESET = 32'h0000_0001;

    // command request from the protocol decoder
    typedef struct packed {
        logic        valid;
        cmd_type     cmd;
        logic [31:0] wdata;
    } cmd_req_type;

    // live status inputs from the analog and monitor logic
    typedef struct packed {
        logic overtemp_off;
        logic temp_over;
        logic cooldown;
        logic heat_alert;
        logic store_bus_err;
        logic reg_saturated;
        logic cur_window;
        logic preset_load_fail;
    } monitor_type;

    // power-on self-test outcome
    typedef struct packed {
        logic done;
        logic config_bad;
        logic preset_bad;
        logic image_bad;
        logic calib_bad;
    } selftest_type;

endpackage

// ---- rtl/driver_status_control_regs.sv ----
// control/status and fault registers of the current driver
//
// Notes on behaviour
// - control write replaces whole 32-bit word
// - bit 0 output switch, set at power-on
// - bit 1 external setpoint, writable only when disabled
// - bit 6 picks pin or bit as enable
// - bit 2 mirrors pin, else writable enable
// - bit 3 reads one when no fault
// - bit 4 loads presets at power-up
// - bit 7 selects external setpoint range
// - any fault bit switches output off
// - self-test flags cleared only by power cycle
// - fault bit 0 reports overtemperature shutdown
// - bits 1,2,3,5 report store check failures
// - fault bit 7 reports preset load failure
// - fault bit 8 reports temperature exceeded
// - bit 9 cooldown, blocks setting bit 2 meanwhile
// - fault bit 10 warns of near-shutdown heat
// - fault bit 11 reports storage bus error
// - bit 12 pin high at power-on, external only
// - bit 13 pin high when switching to external
// - fault bit 15 reports regulator saturation
// - fault bit 16 reports current out of window
`timescale 1ns/100ps
module driver_status_control_regs
    import drv_regs_pkg::*;
(
    input  wire logic         clk_sys,          // system clock, 125 MHz
    input  wire logic         nrst,             // synchronous reset, active low
    input  wire cmd_req_type  cmd_req,          // command from protocol decoder
    output logic              rsp_valid,        // one-cycle answer strobe
    output logic [31:0]       rsp_data,         // answered register word
    input  wire logic         fault_clear_cmd,  // one-cycle clear of clearable faults
    input  wire logic         enable_pin,       // external enable pin, asynchronous
    input  wire monitor_type  monitor,          // live monitor flags
    input  wire selftest_type selftest,         // power-on self-test results
    output logic              output_active,    // drive the output stage
    output logic              driver_enabled,   // effective enable
    output logic              load_presets_at_powerup, // preset load request
    output logic              external_setpoint_select, // external setpoint in use
    output logic              setpoint_range_mode      // 1: zero..max, 0: min..max
);

    logic [31:0] ctrl;          // stored control bits
    logic [31:0] fault;         // stored fault flags
    logic        pin_meta;      // synchroniser first stage
    logic        pin_sync;      // synchronised enable pin
    logic        startup_seen;  // pin level checked after reset
    logic        pin_at_startup; // pin seen high right after reset
    logic [31:0] next_ctrl;
    logic [31:0] ctrl_view;
    logic        no_fault_indicator;
    logic        enable_state;
    logic        write_hit;
    logic        src_to_pin;

    // enable pin synchroniser, kept out of reset on purpose:
    // the power-on check needs a settled pin level in the very
    // first cycle after reset, which a cleared stage would hide
    always_ff @(posedge clk_sys)
    begin
        pin_meta <= enable_pin;
        pin_sync <= pin_meta;
    end

    assign no_fault_indicator = ~|fault;
    // pin or register bit as enable source
    assign enable_state = ctrl[CTL_ENABLE_SRC_PIN] ? pin_sync
                                                   : ctrl[CTL_ENABLE_STATE];
    assign write_hit  = cmd_req.valid && (cmd_req.cmd == CMD_WRITE_CTRL);
    assign src_to_pin = write_hit && cmd_req.wdata[CTL_ENABLE_SRC_PIN]
                        && !ctrl[CTL_ENABLE_SRC_PIN];

    // write value for the control register
    always_comb
    begin
        next_ctrl = cmd_req.wdata & CTL_WRITE_MASK;
        if (enable_state)
            next_ctrl[CTL_EXT_SETPOINT] = ctrl[CTL_EXT_SETPOINT];
        // re-enable refused while cooling down
        if (fault[FLT_COOLDOWN] && !ctrl[CTL_ENABLE_STATE])
            next_ctrl[CTL_ENABLE_STATE] = 1'b0;
    end

    // control register
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            ctrl <= CTL_RESET;
        else if (write_hit)
            ctrl <= next_ctrl;
    end

    // read view of the control register
    always_comb
    begin
        ctrl_view = ctrl;
        ctrl_view[CTL_ENABLE_STATE] = enable_state;
        ctrl_view[CTL_NO_FAULT]     = no_fault_indicator;
    end

    // power-on pin check, one cycle after reset release
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            startup_seen <= 1'b0;
        else
            startup_seen <= 1'b1;
    end

    // pin level seen at power-on, kept until a clear
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            pin_at_startup <= 1'b0;
        else if (!startup_seen)
            pin_at_startup <= pin_sync;
        else if (fault_clear_cmd)
            pin_at_startup <= 1'b0;
    end

    // fault register: live flags, latched events, self-test flags
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            fault <= 32'h0000_0000;
        else
        begin
            if (fault_clear_cmd)
                fault <= fault & FLT_STICKY_MASK;
            // live thermal and monitor flags follow their sources
            fault[FLT_OVERTEMP_OFF] <= monitor.overtemp_off;
            fault[FLT_COOLDOWN]     <= monitor.cooldown;
            fault[FLT_HEAT_ALERT]   <= monitor.heat_alert;
            // events: set wins over the clear
            if (monitor.temp_over)
                fault[FLT_TEMP_OVER] <= 1'b1;
            if (monitor.store_bus_err)
                fault[FLT_STORE_BUS] <= 1'b1;
            if (monitor.reg_saturated)
                fault[FLT_REG_SATURATED] <= 1'b1;
            if (monitor.cur_window)
                fault[FLT_CUR_WINDOW] <= 1'b1;
            if (monitor.preset_load_fail)
                fault[FLT_PRESET_LOAD] <= 1'b1;
            // only meaningful while the pin is the enable source
            if (pin_at_startup && ctrl[CTL_ENABLE_SRC_PIN] && !fault_clear_cmd)
                fault[FLT_PIN_STARTUP] <= 1'b1;
            if (src_to_pin && pin_sync)
                fault[FLT_PIN_SWITCH] <= 1'b1;
            // self-test flags only while the test reports
            if (selftest.done)
            begin
                if (selftest.config_bad)
                    fault[FLT_CONFIG_BAD] <= 1'b1;
                if (selftest.preset_bad)
                    fault[FLT_PRESET_BAD] <= 1'b1;
                if (selftest.image_bad)
                    fault[FLT_IMAGE_BAD] <= 1'b1;
                if (selftest.calib_bad)
                    fault[FLT_CALIB_BAD] <= 1'b1;
            end
        end
    end

    // answer to read and write commands
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            rsp_valid <= 1'b0;
            rsp_data  <= 32'h0000_0000;
        end
        else
        begin
            rsp_valid <= cmd_req.valid && (cmd_req.cmd != CMD_NONE);
            case (cmd_req.cmd)
                CMD_READ_CTRL:  rsp_data <= ctrl_view;
                CMD_WRITE_CTRL: rsp_data <= next_ctrl;
                CMD_READ_FAULT: rsp_data <= fault & FLT_IMPL_MASK;
                default:        rsp_data <= rsp_data;
            endcase
        end
    end

    // output drive and configuration
    assign driver_enabled           = enable_state;
    assign output_active            = ctrl[CTL_OUTPUT_ON] && enable_state
                                      && no_fault_indicator;
    assign load_presets_at_powerup  = ctrl[CTL_PRESETS_PWRUP];
    assign external_setpoint_select = ctrl[CTL_EXT_SETPOINT];
    assign setpoint_range_mode      = ctrl[CTL_SETPOINT_RANGE];

    // checks
    AST_FAULT_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
        (|fault) |-> !output_active)
        else $error("output active with fault set");
    AST_STICKY: assert property (@(posedge clk_sys) disable iff (!nrst)
        fault[FLT_CONFIG_BAD] |=> fault[FLT_CONFIG_BAD])
        else $error("self-test flag cleared");
    AST_WRITE_ALL: assert property (@(posedge clk_sys) disable iff (!nrst)
        (write_hit && !enable_state && !fault[FLT_COOLDOWN])
        |=> ctrl == (($past(cmd_req.wdata)) & CTL_WRITE_MASK))
        else $error("control write not whole word");
    AST_SETPT_LOCK: assert property (@(posedge clk_sys) disable iff (!nrst)
        (write_hit && enable_state) |=> $stable(ctrl[CTL_EXT_SETPOINT]))
        else $error("setpoint select changed while enabled");
    AST_NO_FAULT: assert property (@(posedge clk_sys) disable iff (!nrst)
        ctrl_view[CTL_NO_FAULT] == (fault == 32'h0000_0000))
        else $error("no-fault indicator wrong");
    AST_SRC_PIN: assert property (@(posedge clk_sys) disable iff (!nrst)
        ctrl[CTL_ENABLE_SRC_PIN] |-> (driver_enabled == pin_sync))
        else $error("enable does not follow pin");
    AST_SWITCH_FLAG: assert property (@(posedge clk_sys) disable iff (!nrst)
        (src_to_pin && pin_sync) |=> fault[FLT_PIN_SWITCH])
        else $error("switch flag not set");
    AST_RESERVED: assert property (@(posedge clk_sys) disable iff (!nrst)
        rsp_valid |-> (rsp_data & ~(CTL_WRITE_MASK | FLT_IMPL_MASK | 32'h8)) == 32'h0)
        else $error("reserved bits nonzero");
    AST_REENABLE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (fault[FLT_COOLDOWN] && !ctrl[CTL_ENABLE_STATE]) |=> !ctrl[CTL_ENABLE_STATE])
        else $error("re-enabled during cooldown");

    // power-on pin flag once the pin is the enable source
    AST_STARTUP_FLAG: assert property (@(posedge clk_sys) disable iff (!nrst)
        (pin_at_startup && ctrl[CTL_ENABLE_SRC_PIN] && !fault_clear_cmd)
        |=> fault[FLT_PIN_STARTUP])
        else $error("startup pin flag not set");

    // remaining self-test flags survive any clear
    AST_STICKY_PRESET: assert property (@(posedge clk_sys) disable iff (!nrst)
        fault[FLT_PRESET_BAD] |=> fault[FLT_PRESET_BAD])
        else $error("preset store flag cleared");
    AST_STICKY_IMAGE: assert property (@(posedge clk_sys) disable iff (!nrst)
        fault[FLT_IMAGE_BAD] |=> fault[FLT_IMAGE_BAD])
        else $error("image flag cleared");
    AST_STICKY_CALIB: assert property (@(posedge clk_sys) disable iff (!nrst)
        fault[FLT_CALIB_BAD] |=> fault[FLT_CALIB_BAD])
        else $error("calibration flag cleared");

    // self-test outcome lands in the fault word
    AST_SELFTEST: assert property (@(posedge clk_sys) disable iff (!nrst)
        (selftest.done && selftest.config_bad) |=> fault[FLT_CONFIG_BAD])
        else $error("self-test flag not latched");

    // every command gets exactly one answer strobe
    AST_RSP_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (cmd_req.valid && (cmd_req.cmd != CMD_NONE)) |=> rsp_valid)
        else $error("command not answered");
    AST_RSP_QUIET: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(cmd_req.valid && (cmd_req.cmd != CMD_NONE)) |=> !rsp_valid)
        else $error("answer without command");

    // live thermal flags follow the monitor one cycle later
    AST_OVERTEMP_LIVE: assert property (@(posedge clk_sys) disable iff (!nrst)
        monitor.overtemp_off |=> fault[FLT_OVERTEMP_OFF])
        else $error("overtemperature flag missing");
    AST_COOLDOWN_LIVE: assert property (@(posedge clk_sys) disable iff (!nrst)
        monitor.cooldown |=> fault[FLT_COOLDOWN])
        else $error("cooldown flag missing");
    AST_HEAT_LIVE: assert property (@(posedge clk_sys) disable iff (!nrst)
        monitor.heat_alert |=> fault[FLT_HEAT_ALERT])
        else $error("heat alert flag missing");

    // latched events win over a clear in the same cycle
    AST_TEMP_EVENT: assert property (@(posedge clk_sys) disable iff (!nrst)
        monitor.temp_over |=> fault[FLT_TEMP_OVER])
        else $error("temperature flag missing");
    AST_BUS_EVENT: assert property (@(posedge clk_sys) disable iff (!nrst)
        monitor.store_bus_err |=> fault[FLT_STORE_BUS])
        else $error("storage bus flag missing");
    AST_SAT_EVENT: assert property (@(posedge clk_sys) disable iff (!nrst)
        monitor.reg_saturated |=> fault[FLT_REG_SATURATED])
        else $error("saturation flag missing");
    AST_WINDOW_EVENT: assert property (@(posedge clk_sys) disable iff (!nrst)
        monitor.cur_window |=> fault[FLT_CUR_WINDOW])
        else $error("current window flag missing");
    AST_PRESET_EVENT: assert property (@(posedge clk_sys) disable iff (!nrst)
        monitor.preset_load_fail |=> fault[FLT_PRESET_LOAD])
        else $error("preset load flag missing");

    // register bit is the enable while the pin is not selected
    AST_BIT_SOURCE: assert property (@(posedge clk_sys) disable iff (!nrst)
        !ctrl[CTL_ENABLE_SRC_PIN] |-> (driver_enabled == ctrl[CTL_ENABLE_STATE]))
        else $error("enable does not follow bit");

    // main scenarios
    COV_WRITE: cover property (@(posedge clk_sys) write_hit ##1 rsp_valid);
    COV_CLEAR: cover property (@(posedge clk_sys) fault[FLT_TEMP_OVER] ##1 fault_clear_cmd);
    COV_PIN:   cover property (@(posedge clk_sys) src_to_pin && pin_sync);
    COV_START: cover property (@(posedge clk_sys) pin_at_startup && ctrl[CTL_ENABLE_SRC_PIN]);
    COV_COOL:  cover property (@(posedge clk_sys) fault[FLT_COOLDOWN] && write_hit);

endmodule // driver_status_control_regs

// ---- verif/driver_status_control_regs_bench.sv ----
// testbench: command sequences against the control and fault registers
`timescale 1ns/100ps
module driver_status_control_regs_bench;
    import drv_regs_pkg::*;
    logic         clk_sys, nrst, rsp_valid, fault_clear_cmd, enable_pin;
    logic         output_active, driver_enabled, lp, es, sr, ok;
    logic [31:0]  rsp_data, r;
    cmd_req_type  cmd_req;
    monitor_type  monitor;
    selftest_type selftest;
    int           fail_count, total_checks;
    int           pos[8];
    driver_status_control_regs u_driver_status_control_regs (.clk_sys(clk_sys),
        .nrst(nrst), .cmd_req(cmd_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .fault_clear_cmd(fault_clear_cmd), .enable_pin(enable_pin), .monitor(monitor),
        .selftest(selftest), .output_active(output_active), .driver_enabled(driver_enabled),
        .load_presets_at_powerup(lp), .external_setpoint_select(es),
        .setpoint_range_mode(sr));
    host_model u_host_model (.clk_sys(clk_sys), .cmd_req(cmd_req),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    // clock, 8 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic cmp32(input logic [31:0] got, exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t %0s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, exp, input string m);
        cmp32({31'h0, got}, {31'h0, exp}, m);
    endtask
    task automatic rd(input cmd_type c, input logic [31:0] exp, input string m);
        u_host_model.xfer(c, 32'h0, r, ok);
        cmp1(ok, 1'b1, m);
        cmp32(r, exp, m);
    endtask
    task automatic wr(input logic [31:0] w);
        u_host_model.xfer(CMD_WRITE_CTRL, w, r, ok);
        cmp1(ok, 1'b1, "write answer");
    endtask
    task automatic pulse_clear();
        @(posedge clk_sys);
        #1 fault_clear_cmd = 1'b1;
        @(posedge clk_sys);
        #1 fault_clear_cmd = 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial
    begin
        #40000;
        fail_count++;
        summarize();
    end
    initial
    begin
        pos = '{FLT_OVERTEMP_OFF, FLT_TEMP_OVER, FLT_COOLDOWN, FLT_HEAT_ALERT,
                FLT_STORE_BUS, FLT_REG_SATURATED, FLT_CUR_WINDOW, FLT_PRESET_LOAD};
        nrst = 1'b0; fault_clear_cmd = 1'b0; enable_pin = 1'b0;
        monitor = '0; selftest = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        repeat (16) @(posedge clk_sys);
        #1 nrst = 1'b1;
        rd(CMD_READ_CTRL, 32'h0000_0009, "ctrl after reset");
        rd(CMD_READ_FAULT, 32'h0, "fault after reset");
        $display("test reset done");
        wr(32'hffff_ffff);
        rd(CMD_READ_CTRL, 32'h0000_00db, "full word write");
        cmp1(lp & es & sr, 1'b1, "mode outputs");
        #1 enable_pin = 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(CMD_READ_CTRL, 32'h0000_00df, "pin enable");
        cmp1(output_active & driver_enabled, 1'b1, "pin drives output");
        wr(32'h0000_00d5);
        rd(CMD_READ_CTRL, 32'h0000_00df, "setpoint locked");
        wr(32'h0000_0001);
        rd(CMD_READ_CTRL, 32'h0000_000b, "bit source");
        wr(32'h0000_0041);
        rd(CMD_READ_FAULT, 32'h0000_2000, "pin high at switch");
        rd(CMD_READ_CTRL, 32'h0000_0045, "fault view");
        cmp1(output_active, 1'b0, "fault stops output");
        pulse_clear();
        rd(CMD_READ_FAULT, 32'h0, "switch fault cleared");
        $display("test enable source done");
        #1 enable_pin = 1'b0;
        repeat (3) @(posedge clk_sys);
        wr(32'h0000_0001);
        u_host_model.rmw(32'h0000_0004, 32'h0, ok);
        cmp1(ok, 1'b1, "modify answer");
        rd(CMD_READ_CTRL, 32'h0000_000d, "bit enable");
        cmp1(output_active, 1'b1, "output on");
        for (int i = 0; i < 8; i++)
        begin
            #1 monitor = monitor_type'(8'h80 >> i);
            rd(CMD_READ_FAULT, 32'h1 << pos[i], "monitor flag");
            cmp1(output_active, 1'b0, "flag stops output");
            #1 monitor = '0;
            pulse_clear();
            rd(CMD_READ_FAULT, 32'h0, "flag cleared");
        end
        $display("test monitor flags done");
        wr(32'h0000_0001);
        #1 monitor = monitor_type'(8'h20);
        wr(32'h0000_0005);
        rd(CMD_READ_CTRL, 32'h0000_0001, "cooldown blocks");
        #1 monitor = '0;
        wr(32'h0000_0005);
        rd(CMD_READ_CTRL, 32'h0000_000d, "re-enable");
        $display("test cooldown done");
        #1 nrst = 1'b0;
        enable_pin = 1'b1;
        selftest = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        repeat (3) @(posedge clk_sys);
        #1 nrst = 1'b1;
        rd(CMD_READ_FAULT, 32'h0000_002e, "self-test flags");
        rd(CMD_READ_CTRL, 32'h0000_0001, "ctrl after power-on");
        wr(32'h0000_0041);
        rd(CMD_READ_FAULT, 32'h0000_302e, "pin high at power-on");
        pulse_clear();
        rd(CMD_READ_FAULT, 32'h0000_002e, "sticky flags");
        $display("test self-test done");
        summarize();
    end
endmodule // driver_status_control_regs_bench

// ---- verif/host_model.sv ----
// host model: issues register commands and collects answers
`timescale 1ns/100ps
module host_model
    import drv_regs_pkg::*;
(
    input  wire logic        clk_sys,   // system clock
    output cmd_req_type      cmd_req,   // command to the block
    input  wire logic        rsp_valid, // answer strobe
    input  wire logic [31:0] rsp_data   // answer word
);
    initial cmd_req = '0;
    // one command; answer sampled the cycle after it is taken
    task automatic xfer(input cmd_type c, input logic [31:0] w,
                        output logic [31:0] r, output logic ok);
        @(posedge clk_sys);
        #1 cmd_req = '{1'b1, c, w};
        @(posedge clk_sys);
        #1 cmd_req = '{1'b0, CMD_NONE, ~w}; // idle word no longer valid
        ok = (rsp_valid === 1'b1);
        r = rsp_data;
    endtask
    // single bits changed by read, modify, write of the whole word
    task automatic rmw(input logic [31:0] set_m, clr_m, output logic ok);
        logic [31:0] r;
        logic        ok1;
        xfer(CMD_READ_CTRL, 32'h0, r, ok1);
        xfer(CMD_WRITE_CTRL, (r & ~clr_m) | set_m, r, ok);
        ok = ok & ok1;
    endtask
endmodule // host_model
